//--- rtl/exv_top.v
// Exception vector select: priority, cause capture and register file
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "exv_defs.vh"
module exv_top (
  // Clock and reset
  input  wire                 mclk,
  input  wire                 rst_n,
  // Avalon-MM slave
  input  wire [2:0]           avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [3:0]           avs_byteenable,
  input  wire [31:0]          avs_writedata,
  output reg  [31:0]          avs_readdata,
  output wire                 avs_waitrequest,
  // Exception requests from the pipeline
  input  wire [`EXV_NCLS-1:0] exc_req,
  input  wire                 exc_refill,
  // Accepted exception to fetch
  output wire                 exc_taken,
  output wire [4:0]           exc_class,
  output wire [31:0]          exc_vector,
  output wire                 exc_uncached,
  output wire [4:0]           exc_code,
  output wire                 exc_code_valid
);
  reg         rst_ff1_r;
  reg         rst_ff2_r;
  wire        rst_sync_n;
  reg         ack_r;
  reg  [31:0] ctrl_r;
  reg  [19:0] swbase_r;
  reg  [19:0] rstbase_r;
  reg  [24:0] dbgvec_r;
  reg  [4:0]  cause_code_r;
  reg  [4:0]  cause_cls_r;
  reg         cause_valid_r;
  reg  [31:0] lastvec_r;
  reg  [31:0] ctrl_nxt;
  reg  [31:0] rd_nxt;
  wire        wr_go;
  wire [2:0]  kind;
  wire [5:0]  code_info;
  wire        boot_vector_select;
  wire        exception_level;
  wire [31:0] sw_merged;
  wire [31:0] rb_merged;
  wire [31:0] dg_merged;

  // Byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (be[b])
          merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // Vector kind of an exception class
  function [2:0] kind_of;
    input [4:0] cls;
    input       refill;
    begin
      case (cls)
        `EXV_CLS_RESET, `EXV_CLS_SRESET, `EXV_CLS_NMI:
          kind_of = `EXV_KIND_RST;
        `EXV_CLS_DSS, `EXV_CLS_DINT, `EXV_CLS_DIB, `EXV_CLS_DDB:
          kind_of = `EXV_KIND_DBG;
        `EXV_CLS_ICERR, `EXV_CLS_DCERR:
          kind_of = `EXV_KIND_CERR;
        `EXV_CLS_INT:
          kind_of = `EXV_KIND_INT;
        `EXV_CLS_TLBF, `EXV_CLS_TLBLD, `EXV_CLS_TLBS:
          kind_of = refill ? `EXV_KIND_REFILL : `EXV_KIND_GEN;
        default:
          kind_of = `EXV_KIND_GEN;
      endcase
    end
  endfunction

  // Cause code of a class, top bit set when a code exists
  function [5:0] code_of;
    input [4:0] cls;
    begin
      case (cls)
        `EXV_CLS_INT:                  code_of = {1'b1, `EXV_CODE_INT};
        `EXV_CLS_WATCHF:               code_of = {1'b1, `EXV_CODE_WATCH};
        `EXV_CLS_ADELF, `EXV_CLS_ADELD:
          code_of = {1'b1, `EXV_CODE_ADEL};
        `EXV_CLS_TLBF, `EXV_CLS_TLBLD:
          code_of = {1'b1, `EXV_CODE_TLBL};
        `EXV_CLS_TLBXI:                code_of = {1'b1, `EXV_CODE_TLBXI};
        `EXV_CLS_ICERR, `EXV_CLS_DCERR:
          code_of = {1'b1, `EXV_CODE_CERR};
        `EXV_CLS_IBE:                  code_of = {1'b1, `EXV_CODE_IBE};
        `EXV_CLS_SYS:                  code_of = {1'b1, `EXV_CODE_SYS};
        `EXV_CLS_BP:                   code_of = {1'b1, `EXV_CODE_BP};
        `EXV_CLS_RI:                   code_of = {1'b1, `EXV_CODE_RI};
        `EXV_CLS_OV:                   code_of = {1'b1, `EXV_CODE_OV};
        `EXV_CLS_ADES:                 code_of = {1'b1, `EXV_CODE_ADES};
        `EXV_CLS_TLBS:                 code_of = {1'b1, `EXV_CODE_TLBS};
        `EXV_CLS_MOD:                  code_of = {1'b1, `EXV_CODE_MOD};
        `EXV_CLS_DBE:                  code_of = {1'b1, `EXV_CODE_DBE};
        default:                       code_of = 6'h00;
      endcase
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_ff1_r <= 1'b0;
      rst_ff2_r <= 1'b0;
    end
    else
    begin
      rst_ff1_r <= 1'b1;
      rst_ff2_r <= rst_ff1_r;
    end
  end
  assign rst_sync_n = rst_ff2_r;

  // Highest priority request wins
  exv_prio u_prio (
    .req   (exc_req),
    .taken (exc_taken),
    .idx   (exc_class)
  );

  assign boot_vector_select       = ctrl_r[`EXV_CTRL_BEV];
  assign exception_level       = ctrl_r[`EXV_CTRL_EXL];
  assign kind      = kind_of(exc_class, exc_refill);
  assign code_info = code_of(exc_class);
  assign exc_code       = code_info[4:0];
  assign exc_code_valid = exc_taken & code_info[5];

  // Vector formed in the same cycle as the pick
  exv_vecsel u_vecsel (
    .kind     (kind),
    .exception_level      (exception_level),
    .iv       (ctrl_r[`EXV_CTRL_IV]),
    .boot_vector_select      (boot_vector_select),
    .kmode    (ctrl_r[`EXV_CTRL_KMODE]),
    .ovr      (ctrl_r[`EXV_CTRL_OVR]),
    .probe    (ctrl_r[`EXV_CTRL_PROBE]),
    .reloc    (ctrl_r[`EXV_CTRL_RELOC]),
    .cv       (ctrl_r[`EXV_CTRL_CV]),
    .sw_base  (swbase_r),
    .rst_base (rstbase_r),
    .dbg_addr (dbgvec_r),
    .vector   (exc_vector),
    .uncached (exc_uncached)
  );

  // One wait cycle, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r;

  // Write merged into each base register's full word, low bits cut below
  assign sw_merged = merge({swbase_r, 12'h000}, avs_writedata,
                           avs_byteenable);
  assign rb_merged = merge({rstbase_r, 12'h000}, avs_writedata,
                           avs_byteenable);
  assign dg_merged = merge({dbgvec_r, 7'h00}, avs_writedata,
                           avs_byteenable);

  // Control word: software write, then hardware sets win
  always @*
  begin
    ctrl_nxt = ctrl_r;
    if (wr_go && avs_address == `EXV_REG_CTRL)
      ctrl_nxt = merge(ctrl_r, avs_writedata, avs_byteenable);
    ctrl_nxt[31:`EXV_CTRL_VS_HI+1] = 19'h00000;
    if (exc_taken)
    begin
      if (kind == `EXV_KIND_RST)
        ctrl_nxt[`EXV_CTRL_BEV] = 1'b1;
      else if (kind != `EXV_KIND_DBG)
        ctrl_nxt[`EXV_CTRL_EXL] = 1'b1;
    end
  end

  // Read data selection
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    if (avs_address == `EXV_REG_CTRL)
      rd_nxt = ctrl_r;
    else if (avs_address == `EXV_REG_SWBASE)
      rd_nxt = {swbase_r, 12'h000};
    else if (avs_address == `EXV_REG_RSTBASE)
      rd_nxt = {rstbase_r, 12'h000};
    else if (avs_address == `EXV_REG_DBGVEC)
      rd_nxt = {dbgvec_r, 7'h00};
    else if (avs_address == `EXV_REG_CAUSE)
    begin
      rd_nxt[`EXV_CAUSE_CODE_HI:`EXV_CAUSE_CODE_LO] = cause_code_r;
      rd_nxt[`EXV_CAUSE_CLS_HI:`EXV_CAUSE_CLS_LO]   = cause_cls_r;
      rd_nxt[`EXV_CAUSE_VALID]                      = cause_valid_r;
    end
    else if (avs_address == `EXV_REG_LASTVEC)
      rd_nxt = lastvec_r;
  end

  // Register file and capture of the taken exception
  always @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ack_r         <= 1'b0;
      avs_readdata  <= 32'h0000_0000;
      ctrl_r        <= `EXV_RST_CTRL;
      swbase_r      <= `EXV_RST_SWBASE;
      rstbase_r     <= `EXV_RST_RSTBASE;
      dbgvec_r      <= `EXV_RST_DBGVEC;
      cause_code_r  <= 5'h00;
      cause_cls_r   <= 5'h00;
      cause_valid_r <= 1'b0;
      lastvec_r     <= 32'h0000_0000;
    end
    else
    begin
      ack_r  <= (avs_read | avs_write) & ~ack_r;
      ctrl_r <= ctrl_nxt;
      if (avs_read && !ack_r)
        avs_readdata <= rd_nxt;
      if (wr_go && avs_address == `EXV_REG_SWBASE)
        swbase_r <= sw_merged[31:12];
      if (wr_go && avs_address == `EXV_REG_RSTBASE)
        rstbase_r <= rb_merged[31:12];
      if (wr_go && avs_address == `EXV_REG_DBGVEC)
        dbgvec_r <= dg_merged[31:7];
      if (exc_taken)
      begin
        cause_cls_r   <= exc_class;
        cause_valid_r <= code_info[5];
        lastvec_r     <= exc_vector;
        if (code_info[5])
          cause_code_r <= code_info[4:0];
      end
    end
  end
endmodule // exv_top

//--- pkg/exv_defs.vh
// Constants for the exception vector select block
`ifndef EXV_DEFS_VH
`define EXV_DEFS_VH
// Register word indices (byte address = index * 4)
`define EXV_REG_CTRL     3'h0
`define EXV_REG_SWBASE   3'h1
`define EXV_REG_RSTBASE  3'h2
`define EXV_REG_DBGVEC   3'h3
`define EXV_REG_CAUSE    3'h4
`define EXV_REG_LASTVEC  3'h5
// Control register fields
`define EXV_CTRL_BEV     0
`define EXV_CTRL_EXL     1
`define EXV_CTRL_IV      2
`define EXV_CTRL_KMODE   3
`define EXV_CTRL_OVR     4
`define EXV_CTRL_PROBE   5
`define EXV_CTRL_RELOC   6
`define EXV_CTRL_CV      7
`define EXV_CTRL_VS_LO   8
`define EXV_CTRL_VS_HI   12
// Cause register fields
`define EXV_CAUSE_CODE_LO  0
`define EXV_CAUSE_CODE_HI  4
`define EXV_CAUSE_CLS_LO   8
`define EXV_CAUSE_CLS_HI   12
`define EXV_CAUSE_VALID    16
// Reset values
`define EXV_RST_CTRL     32'h0000_0001
`define EXV_RST_SWBASE   20'h80000
`define EXV_RST_RSTBASE  20'hBFC00
`define EXV_RST_DBGVEC   25'h0000000
// Vector bases and offsets
`define EXV_LEGACY_BASE  20'hBFC00
`define EXV_SEG_TOP      2'b10
`define EXV_CERR_TOP     3'b101
`define EXV_PROBE_VEC    32'hFF20_0200
`define EXV_OFS_RST      12'h000
`define EXV_OFS_DBG      12'h480
`define EXV_OFS_CERR_BT  12'h300
`define EXV_OFS_CERR_SW  12'h100
`define EXV_OFS_REF_SW   12'h000
`define EXV_OFS_GEN_SW   12'h180
`define EXV_OFS_INT_SW   12'h200
`define EXV_OFS_REF_BT   12'h200
`define EXV_OFS_GEN_BT   12'h380
`define EXV_OFS_INT_BT   12'h400
// Vector kinds
`define EXV_KIND_RST     3'h0
`define EXV_KIND_DBG     3'h1
`define EXV_KIND_CERR    3'h2
`define EXV_KIND_REFILL  3'h3
`define EXV_KIND_INT     3'h4
`define EXV_KIND_GEN     3'h5
// Exception classes, index 0 highest priority
`define EXV_NCLS         25
`define EXV_CLS_RESET    5'd0
`define EXV_CLS_SRESET   5'd1
`define EXV_CLS_DSS      5'd2
`define EXV_CLS_DINT     5'd3
`define EXV_CLS_NMI      5'd4
`define EXV_CLS_INT      5'd5
`define EXV_CLS_WATCHF   5'd6
`define EXV_CLS_DIB      5'd7
`define EXV_CLS_ADELF    5'd8
`define EXV_CLS_TLBF     5'd9
`define EXV_CLS_TLBXI    5'd10
`define EXV_CLS_ICERR    5'd11
`define EXV_CLS_IBE      5'd12
`define EXV_CLS_SYS      5'd13
`define EXV_CLS_BP       5'd14
`define EXV_CLS_RI       5'd15
`define EXV_CLS_OV       5'd16
`define EXV_CLS_DDB      5'd17
`define EXV_CLS_ADELD    5'd18
`define EXV_CLS_ADES     5'd19
`define EXV_CLS_TLBLD    5'd20
`define EXV_CLS_TLBS     5'd21
`define EXV_CLS_MOD      5'd22
`define EXV_CLS_DCERR    5'd23
`define EXV_CLS_DBE      5'd24
// Cause codes
`define EXV_CODE_INT     5'h00
`define EXV_CODE_MOD     5'h01
`define EXV_CODE_TLBL    5'h02
`define EXV_CODE_TLBS    5'h03
`define EXV_CODE_ADEL    5'h04
`define EXV_CODE_ADES    5'h05
`define EXV_CODE_IBE     5'h06
`define EXV_CODE_DBE     5'h07
`define EXV_CODE_SYS     5'h08
`define EXV_CODE_BP      5'h09
`define EXV_CODE_RI      5'h0A
`define EXV_CODE_OV      5'h0C
`define EXV_CODE_TLBXI   5'h14
`define EXV_CODE_WATCH   5'h17
`define EXV_CODE_CERR    5'h1E
`endif

//--- rtl/exv_prio.v
// Fixed priority pick among simultaneous exception requests
`timescale 1ns/1ps
`include "exv_defs.vh"
module exv_prio (
  // Requests, bit 0 highest
  input  wire [`EXV_NCLS-1:0] req,
  // Winner
  output reg                  taken,
  output reg  [4:0]           idx
);
  integer i;

  // Scan from the highest index downward so the highest priority wins
  always @*
  begin
    taken = 1'b0;
    idx   = 5'h00;
    for (i = `EXV_NCLS - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        taken = 1'b1;
        idx   = i[4:0];
      end
    end
  end
endmodule // exv_prio

//--- rtl/exv_vecsel.v
// Vector address selection from kind, mode and base values
`timescale 1ns/1ps
`include "exv_defs.vh"
module exv_vecsel (
  // Kind and state bits
  input  wire [2:0]  kind,
  input  wire        exception_level,
  input  wire        iv,
  input  wire        boot_vector_select,
  input  wire        kmode,
  input  wire        ovr,
  input  wire        probe,
  input  wire        reloc,
  input  wire        cv,
  // Base values
  input  wire [19:0] sw_base,
  input  wire [19:0] rst_base,
  input  wire [24:0] dbg_addr,
  // Result
  output reg  [31:0] vector,
  output reg         uncached
);
  reg [19:0] boot_base;
  reg [19:0] sw_eff;
  reg [11:0] ofs;

  always @*
  begin
    // Boot base; extended mode ignores the override bit
    if (kmode)
      boot_base = rst_base;
    else if (ovr)
      boot_base = {`EXV_SEG_TOP, rst_base[17:0]};
    else
      boot_base = `EXV_LEGACY_BASE;
    // Software base, top bits pinned in legacy; override unused
    if (kmode)
      sw_eff = sw_base;
    else
      sw_eff = {`EXV_SEG_TOP, sw_base[17:0]};
    uncached = 1'b0;
    ofs      = `EXV_OFS_GEN_SW;
    vector   = {boot_base, `EXV_OFS_RST};
    case (kind)
      `EXV_KIND_RST:
        vector = {boot_base, `EXV_OFS_RST};
      `EXV_KIND_DBG:
      begin
        if (probe)
          vector = `EXV_PROBE_VEC;
        else if (reloc)
          vector = {dbg_addr, 7'h00};
        else
          vector = {boot_base, `EXV_OFS_DBG};
      end
      `EXV_KIND_CERR:
      begin
        if (boot_vector_select)
        begin
          uncached = kmode;
          if (!kmode && ovr)
            vector = {`EXV_CERR_TOP, rst_base[16:0],
                      `EXV_OFS_CERR_BT};
          else
            vector = {boot_base, `EXV_OFS_CERR_BT};
        end
        else if (!kmode)
          vector = {sw_eff[19:18], 1'b1, sw_eff[16:0],
                    `EXV_OFS_CERR_SW};
        else if (cv)
          vector = {sw_base, `EXV_OFS_CERR_SW};
        else
          vector = {`EXV_LEGACY_BASE, `EXV_OFS_CERR_SW};
      end
      default:
      begin
        // Vectored spacing assumed zero; one flat offset
        if (boot_vector_select)
        begin
          if (kind == `EXV_KIND_REFILL && !exception_level)
            ofs = `EXV_OFS_REF_BT;
          else if (kind == `EXV_KIND_INT && iv)
            ofs = `EXV_OFS_INT_BT;
          else
            ofs = `EXV_OFS_GEN_BT;
          vector = {boot_base, ofs};
        end
        else
        begin
          if (kind == `EXV_KIND_REFILL && !exception_level)
            ofs = `EXV_OFS_REF_SW;
          else if (kind == `EXV_KIND_INT && iv)
            ofs = `EXV_OFS_INT_SW;
          else
            ofs = `EXV_OFS_GEN_SW;
          vector = {sw_eff, ofs};
        end
      end
    endcase
  end
endmodule // exv_vecsel

//--- testbench/exv_top_assertions.sv
// Assertion checker for the exception vector select top
`timescale 1ns/1ps
`include "exv_defs.vh"
module exv_top_assertions (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // Register bus
  input wire logic [2:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  // Exception port
  input wire logic [`EXV_NCLS-1:0] exc_req,
  input wire logic                 exc_taken,
  input wire logic [4:0]           exc_class,
  input wire logic [31:0]          exc_vector,
  input wire logic [4:0]           exc_code,
  input wire logic                 exc_code_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Requests of higher priority than the reported winner
  wire [`EXV_NCLS-1:0] above;
  wire                 no_code;
  assign above   = exc_req & ((25'h1 << exc_class) - 25'h1);
  assign no_code = exc_class < 5'd5 || exc_class == 5'd7
                   || exc_class == 5'd17;
  sequence s_req_start;
    $rose(avs_read) || $rose(avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_taken_any: assert property (exc_taken == (|exc_req))
    else $error("taken flag does not follow the requests");
  a_prio_win: assert property (exc_taken |->
    exc_req[exc_class] && above == 25'h0)
    else $error("winner is not the highest pending request");
  a_lowest_last: assert property (
    exc_req == 25'h100_0000 |-> exc_class == 5'd24 && exc_code == 5'h07)
    else $error("lowest class reported wrongly");
  a_code_needs: assert property (exc_code_valid |-> exc_taken)
    else $error("cause code valid without an exception");
  a_int_code: assert property (
    exc_taken && exc_class == 5'd5 |-> exc_code_valid && exc_code == 5'h00)
    else $error("interrupt cause code wrong");
  a_dbg_nocode: assert property (
    exc_taken && no_code |-> !exc_code_valid)
    else $error("codeless class flagged with a code");
  a_vec_align: assert property (
    exc_taken |-> exc_vector[6:0] == 7'h00)
    else $error("vector not on a 128 byte boundary");
  a_unmapped_zero: assert property (
    avs_read && avs_address[2:1] == 2'b11 && !avs_waitrequest
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_wait_one: assert property (s_req_start |-> s_one_wait)
    else $error("bus answer not after one wait cycle");
endmodule // exv_top_assertions
bind exv_top exv_top_assertions exv_top_assertions_inst (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .exc_req(exc_req), .exc_taken(exc_taken), .exc_class(exc_class),
  .exc_vector(exc_vector), .exc_code(exc_code),
  .exc_code_valid(exc_code_valid)
);

//--- testbench/exv_pipe_model.sv
// Pipeline-side model that raises exception requests
`timescale 1ns/1ps
module exv_pipe_model (
  // Clock
  input  wire logic  mclk,
  // Requests toward the block
  output logic [24:0] exc_req,
  output logic        exc_refill
);
  initial
  begin
    exc_req    = 25'h0;
    exc_refill = 1'b0;
  end
  // One-cycle request after an idle gap, as the pipeline pulses
  task automatic pulse(input logic [24:0] r, input logic rf, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    exc_req    <= r;
    exc_refill <= rf;
    @(posedge mclk);
    exc_req    <= 25'h0;
    // Qualifier means nothing once the request drops
    exc_refill <= ~rf;
  endtask
endmodule // exv_pipe_model

//--- testbench/exv_top_tb.sv
// Self-checking bench for the exception vector select top
`timescale 1ns/1ps
`include "exv_defs.vh"
module exv_top_tb;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  wire  [31:0] avs_readdata, exc_vector;
  wire  [24:0] exc_req;
  wire  [4:0]  exc_class, exc_code;
  wire         avs_waitrequest, exc_refill, exc_taken;
  wire         exc_uncached, exc_code_valid;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  integer      seed = 32'hB6466EF3;
  logic [43:0] eq[$];
  logic [31:0] rq[$];
  logic [31:0] ctl, sw, rb, dg, lastvec, lastcause;
  logic [4:0]  lastcode, c;
  logic [31:0] rv[8] = '{32'h1, 32'h8000_0000, 32'hBFC0_0000, 0, 0, 0, 0, 0};
  logic [31:0] av[8] = '{32'h1FFF, 32'hFFFF_F000, 32'hFFC0_0000,
                         32'hFFFF_FF80, 0, 0, 0, 0};
  logic [4:0]  ct[12] = '{0, 1, 4, 2, 7, 11, 23, 9, 20, 21, 5, 13};
  exv_top exv_top_inst (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .exc_req(exc_req),
    .exc_refill(exc_refill), .exc_taken(exc_taken),
    .exc_class(exc_class), .exc_vector(exc_vector),
    .exc_uncached(exc_uncached), .exc_code(exc_code),
    .exc_code_valid(exc_code_valid));
  exv_pipe_model exv_pipe_model_inst (.mclk(mclk), .exc_req(exc_req),
    .exc_refill(exc_refill));
  always #12.5 mclk = ~mclk;
  task automatic chk(input logic [43:0] g, input logic [43:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Result watcher: each appearing result takes the oldest note
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (exc_taken !== 1'b0)
      chk({exc_class, exc_code_valid ? exc_code : 5'h0, exc_code_valid,
           exc_uncached, exc_vector},
          eq.size() > 0 ? eq.pop_front() : 'x);
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk({12'h0, avs_readdata},
          rq.size() > 0 ? {12'h0, rq.pop_front()} : 'x);
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop;
    end
  end
  // One bus transfer; for reads d is the expected data
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_address    <= a;
    avs_read       <= ~w;
    avs_write      <= w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    if (!w)
      rq.push_back(d);
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [31:0] vec_of(input logic [4:0] k, input logic rf);
    logic [19:0] bb, sb;
    bb = ctl[3] ? rb[31:12] : ctl[4] ? {2'b10, rb[29:12]} : 20'hBFC00;
    sb = ctl[3] ? sw[31:12] : {2'b10, sw[29:12]};
    if (k == 0 || k == 1 || k == 4)
      return {bb, 12'h000};
    if (k == 2 || k == 3 || k == 7 || k == 17)
      return ctl[5] ? 32'hFF20_0200 : ctl[6] ? {dg[31:7], 7'h0}
             : {bb, 12'h480};
    if (k == 11 || k == 23)
      return ctl[0] ? (ctl[3] ? {rb[31:12], 12'h300} : ctl[4] ?
        {3'b101, rb[28:12], 12'h300} : 32'hBFC0_0300) : ctl[3] ? (ctl[7] ?
        {sw[31:12], 12'h100} : 32'hBFC0_0100) : {3'b101, sw[28:12], 12'h100};
    if (rf && (k == 9 || k == 20 || k == 21))
      return ctl[0] ? {bb, ctl[1] ? 12'h380 : 12'h200}
                    : {sb, ctl[1] ? 12'h180 : 12'h000};
    if (k == 5 && ctl[2])
      return ctl[0] ? {bb, 12'h400} : {sb, 12'h200};
    return ctl[0] ? {bb, 12'h380} : {sb, 12'h180};
  endfunction
  function automatic logic [5:0] code_of(input logic [4:0] k);
    case (k)
      5: return 6'h20;
      6: return 6'h37;
      8, 18: return 6'h24;
      9, 20: return 6'h22;
      10: return 6'h34;
      11, 23: return 6'h3E;
      12: return 6'h26;
      13: return 6'h28;
      14: return 6'h29;
      15: return 6'h2A;
      16: return 6'h2C;
      19: return 6'h25;
      21: return 6'h23;
      22: return 6'h21;
      24: return 6'h27;
      default: return 6'h00;
    endcase
  endfunction
  // Note the expected result, pulse the request, track side effects
  task automatic take(input logic [24:0] r, input logic rf,
                      input logic [4:0] k);
    logic [5:0] cd;
    cd = code_of(k);
    lastvec = vec_of(k, rf);
    // Uncached flag only for boot-time cache errors in extended mode
    eq.push_back({k, cd[5] ? cd[4:0] : 5'h0, cd[5],
                  (k == 11 || k == 23) && ctl[0] && ctl[3], lastvec});
    exv_pipe_model_inst.pulse(r, rf, $unsigned($random(seed)) % 3);
    if (cd[5])
      lastcode = cd[4:0];
    lastcause = {15'h0, cd[5], 3'h0, k, 3'h0, lastcode};
    if (k == 0 || k == 1 || k == 4)
      ctl[0] = 1'b1;
    else if (!(k == 2 || k == 3 || k == 7 || k == 17))
      ctl[1] = 1'b1;
  endtask
  initial
  begin
    ctl = 32'h1;
    lastcode = 5'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 8; i++)
      bus(1'b0, 3'(i), rv[i], 4'hF);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
      bus(1'b1, 3'(i), 32'hFFFF_FFFF, i == 2 ? 4'h8 : 4'hF);
    for (int i = 0; i < 8; i++)
      bus(1'b0, 3'(i), av[i], 4'hF);
    $display("test access kinds done");
    for (int i = 0; i < 72; i++)
    begin
      ctl = {19'h0, 13'($random(seed))};
      sw = $random(seed) & 32'hFFFF_F000;
      rb = $random(seed) & 32'hFFFF_F000;
      dg = $random(seed) & 32'hFFFF_FF80;
      bus(1'b1, 3'h0, ctl, 4'hF);
      bus(1'b1, 3'h1, sw, 4'hF);
      bus(1'b1, 3'h2, rb, 4'hF);
      bus(1'b1, 3'h3, dg, 4'hF);
      c = ct[i % 12];
      take(25'h1 << c, 1'($random(seed)), c);
      bus(1'b0, 3'h5, lastvec, 4'hF);
      bus(1'b0, 3'h4, lastcause, 4'hF);
    end
    $display("test vector table done");
    for (int i = 0; i < 25; i++)
    begin
      c = 5'(i);
      take((25'($random(seed)) << c) | (25'h1 << c),
           1'($random(seed)), c);
      bus(1'b0, 3'h4, lastcause, 4'hF);
    end
    $display("test priority done");
    repeat (5) @(posedge mclk);
    if (eq.size() != 0 || rq.size() != 0)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, eq.size(), 0);
    end
    report_and_stop;
  end
endmodule // exv_top_tb
